// ===== hdl/tepi_consts.vh
// Constants for the transmit errored-packet insertion and counter block
`ifndef TEPI_CONSTS_VH
`define TEPI_CONSTS_VH

// Register indices (printed offsets are not all multiples of four)
`define TEPI_IDX_CTRL_LOW 8'hC4
`define TEPI_IDX_ERR_COUNT 8'hC6
`define TEPI_IDX_ERR_RATE 8'hC7
`define TEPI_IDX_DONE_STATUS 8'hC8
`define TEPI_IDX_DONE_LATCHED 8'hC9
`define TEPI_IDX_DONE_IRQ_EN 8'hCA
`define TEPI_IDX_PKT_B0 8'hCC
`define TEPI_IDX_PKT_B1 8'hCD
`define TEPI_IDX_PKT_B2 8'hCE
`define TEPI_IDX_BYTE_B0 8'hD0
`define TEPI_IDX_BYTE_B1 8'hD1
`define TEPI_IDX_BYTE_B2 8'hD2
`define TEPI_IDX_BYTE_B3 8'hD3
`define TEPI_IDX_PERF_UPDATE 8'hD6

// Byte address is four times the index
`define TEPI_ADDR_W 12
`define TEPI_ADDR_LSB 2
`define TEPI_IDX_W 10

// Field positions and values
`define TEPI_BIT_INITIATE 0
`define TEPI_BIT_FINISHED 0
`define TEPI_BIT_UPDATE 0
`define TEPI_COUNT_CONTINUOUS 8'hFF
`define TEPI_RATE_X_HI 3
`define TEPI_RATE_Y_HI 6
`define TEPI_RATE_Y_LO 4
`define TEPI_RATE_Y_MAX 3'h6
`define TEPI_RESET_BYTE 8'h00
`define TEPI_RESP_OKAY 2'h0
`define TEPI_RESP_SLVERR 2'h2

`endif

// ===== hdl/tepi_rate_gen.v
// Rate divider that flags one packet in every x times ten to the y, with y held at 6 at most
`include "tepi_consts.vh"

module tepi_rate_gen
(
    input wire clk,
    input wire rst,
    input wire restart,
    input wire [6:0] rate,
    input wire pkt_done,
    output reg hit
);

    // *****************************************************************
    // Period from rate code
    // *****************************************************************
    function [27:0] tepi_period;
        input [6:0] code;
        reg [2:0] y;
        reg [27:0] p;
        integer i;
        begin
            y = code[`TEPI_RATE_Y_HI:`TEPI_RATE_Y_LO];
            if (y > `TEPI_RATE_Y_MAX)
                y = `TEPI_RATE_Y_MAX;
            p = {24'h000000, code[`TEPI_RATE_X_HI:0]};
            for (i = 0; i < `TEPI_RATE_Y_MAX; i = i + 1)
                if (i < y)
                    p = p * 28'h000000A;
            tepi_period = p;
        end
    endfunction

    reg [27:0] cnt_q;
    wire [27:0] period = tepi_period(rate);

    // *****************************************************************
    // Packet counter
    // *****************************************************************
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= 28'h0000000;
            hit <= 1'b0;
        end
        else
        begin
            hit <= 1'b0;
            if (restart)
                cnt_q <= 28'h0000000;
            else if (pkt_done && period != 28'h0000000)
            begin
                if (cnt_q + 28'h0000001 >= period)
                begin
                    cnt_q <= 28'h0000000;
                    hit <= 1'b1;
                end
                else
                    cnt_q <= cnt_q + 28'h0000001;
            end
        end
    end

endmodule // tepi_rate_gen

// ===== hdl/tepi_top.v
// Transmit errored-packet insertion, finish flags and traffic counters
//
// Design decision made here: the AXI4-Lite register port.
`include "tepi_consts.vh"

module tepi_top
(
    input wire clk,
    input wire rst,
    input wire [`TEPI_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`TEPI_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire tx_pkt_done,
    input wire tx_byte_valid,
    output reg tx_pkt_error,
    output reg irq
);

    // *****************************************************************
    // Registers
    // *****************************************************************
    reg [7:0] ctrl_low_q;
    reg [7:0] err_count_q;
    reg [7:0] err_rate_q;
    reg active_q;
    reg [7:0] sent_q;
    reg finished_q;
    reg finished_latched_q;
    reg irq_en_q;
    reg update_q;
    reg [23:0] pkt_run_q;
    reg [31:0] byte_run_q;
    reg [23:0] tx_packet_total_q;
    reg [31:0] tx_byte_total_q;

    reg [`TEPI_ADDR_W-1:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg aw_held_q;
    reg w_held_q;

    wire err_hit;
    wire start_run;
    wire wr_fire;
    wire [`TEPI_IDX_W-1:0] wr_idx;
    wire [`TEPI_IDX_W-1:0] rd_idx;
    wire wr_lane0;
    wire update_rise;
    wire run_stop;

    // *****************************************************************
    // Write channel capture, either order
    // *****************************************************************
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= {`TEPI_ADDR_W{1'b0}};
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TEPI_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awaddr_q <= s_axi_awaddr;
                aw_held_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                w_held_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known(wr_idx) ? `TEPI_RESP_OKAY
                                                : `TEPI_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wr_idx = awaddr_q[`TEPI_ADDR_W-1:`TEPI_ADDR_LSB];
    assign wr_lane0 = wr_fire && wstrb_q[0];

    // *****************************************************************
    // Address decode helpers
    // *****************************************************************
    function wr_known;
        input [`TEPI_IDX_W-1:0] idx;
        begin
            case (idx)
                `TEPI_IDX_CTRL_LOW, `TEPI_IDX_ERR_COUNT,
                `TEPI_IDX_ERR_RATE, `TEPI_IDX_DONE_LATCHED,
                `TEPI_IDX_DONE_IRQ_EN, `TEPI_IDX_PERF_UPDATE:
                    wr_known = 1'b1;
                default:
                    wr_known = 1'b0;
            endcase
        end
    endfunction

    function wr_hits;
        input [`TEPI_IDX_W-1:0] idx;
        input [7:0] want;
        begin
            wr_hits = (idx == {2'b00, want});
        end
    endfunction

    // *****************************************************************
    // Control registers written by software
    // *****************************************************************
    assign start_run = wr_lane0 && wr_hits(wr_idx, `TEPI_IDX_CTRL_LOW)
                       && wdata_q[`TEPI_BIT_INITIATE];

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_low_q <= `TEPI_RESET_BYTE;
            err_count_q <= `TEPI_RESET_BYTE;
            err_rate_q <= `TEPI_RESET_BYTE;
            irq_en_q <= 1'b0;
            update_q <= 1'b0;
        end
        else if (wr_lane0)
        begin
            if (wr_hits(wr_idx, `TEPI_IDX_CTRL_LOW))
                ctrl_low_q <= wdata_q[7:0];
            if (wr_hits(wr_idx, `TEPI_IDX_ERR_COUNT))
                err_count_q <= wdata_q[7:0];
            if (wr_hits(wr_idx, `TEPI_IDX_ERR_RATE))
                err_rate_q <= wdata_q[7:0];
            if (wr_hits(wr_idx, `TEPI_IDX_DONE_IRQ_EN))
                irq_en_q <= wdata_q[`TEPI_BIT_FINISHED];
            if (wr_hits(wr_idx, `TEPI_IDX_PERF_UPDATE))
                update_q <= wdata_q[`TEPI_BIT_UPDATE];
        end
    end

    // *****************************************************************
    // Automatic insertion run
    // *****************************************************************
    tepi_rate_gen u_rate
    (
        .clk(clk),
        .rst(rst),
        .restart(start_run),
        .rate(err_rate_q[6:0]),
        .pkt_done(tx_pkt_done && active_q),
        .hit(err_hit)
    );

    // Insertion counts as disabled when initiate or rate x is zero
    assign run_stop = !ctrl_low_q[`TEPI_BIT_INITIATE]
                      || err_rate_q[`TEPI_RATE_X_HI:0] == 4'h0;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            active_q <= 1'b0;
            sent_q <= 8'h00;
            finished_q <= 1'b0;
            tx_pkt_error <= 1'b0;
        end
        else
        begin
            tx_pkt_error <= 1'b0;
            if (start_run)
            begin
                active_q <= 1'b1;
                sent_q <= 8'h00;
                finished_q <= 1'b0;
            end
            else if (active_q && run_stop)
            begin
                active_q <= 1'b0;
                finished_q <= 1'b0;
            end
            else if (!active_q && run_stop)
                finished_q <= 1'b0;
            else if (active_q && err_hit)
            begin
                tx_pkt_error <= 1'b1;
                if (err_count_q != `TEPI_COUNT_CONTINUOUS)
                begin
                    sent_q <= sent_q + 8'h01;
                    if (sent_q + 8'h01 >= err_count_q)
                    begin
                        active_q <= 1'b0;
                        finished_q <= 1'b1;
                    end
                end
            end
        end
    end

    // *****************************************************************
    // Latched flag and interrupt
    // *****************************************************************
    reg finished_prev_q;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            finished_prev_q <= 1'b0;
            finished_latched_q <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            finished_prev_q <= finished_q;
            if (finished_q && !finished_prev_q)
                finished_latched_q <= 1'b1;
            else if (wr_lane0 && wr_hits(wr_idx, `TEPI_IDX_DONE_LATCHED)
                     && wdata_q[`TEPI_BIT_FINISHED])
                finished_latched_q <= 1'b0;
            irq <= finished_latched_q && irq_en_q;
        end
    end

    // *****************************************************************
    // Traffic counters with snapshot on update rise
    // *****************************************************************
    reg update_prev_q;
    assign update_rise = update_q && !update_prev_q;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            update_prev_q <= 1'b0;
            pkt_run_q <= 24'h000000;
            byte_run_q <= 32'h00000000;
            tx_packet_total_q <= 24'h000000;
            tx_byte_total_q <= 32'h00000000;
        end
        else
        begin
            update_prev_q <= update_q;
            if (update_rise)
            begin
                tx_packet_total_q <= pkt_run_q
                    + {23'h000000, tx_pkt_done};
                tx_byte_total_q <= byte_run_q
                    + {31'h00000000, tx_byte_valid};
                pkt_run_q <= 24'h000000;
                byte_run_q <= 32'h00000000;
            end
            else
            begin
                if (tx_pkt_done)
                    pkt_run_q <= pkt_run_q + 24'h000001;
                if (tx_byte_valid)
                    byte_run_q <= byte_run_q + 32'h00000001;
            end
        end
    end

    // *****************************************************************
    // Read channel
    // *****************************************************************
    assign rd_idx = s_axi_araddr[`TEPI_ADDR_W-1:`TEPI_ADDR_LSB];

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `TEPI_RESP_OKAY;
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
        else if (s_axi_arvalid)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `TEPI_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            case (rd_idx[7:0] & {8{rd_idx[9:8] == 2'b00}})
                `TEPI_IDX_CTRL_LOW:
                    s_axi_rdata[7:0] <= {ctrl_low_q[7:1], 1'b0};
                `TEPI_IDX_ERR_COUNT:
                    s_axi_rdata[7:0] <= err_count_q;
                `TEPI_IDX_ERR_RATE:
                    s_axi_rdata[7:0] <= err_rate_q;
                `TEPI_IDX_DONE_STATUS:
                    s_axi_rdata[0] <= finished_q;
                `TEPI_IDX_DONE_LATCHED:
                    s_axi_rdata[0] <= finished_latched_q;
                `TEPI_IDX_DONE_IRQ_EN:
                    s_axi_rdata[0] <= irq_en_q;
                `TEPI_IDX_PKT_B0:
                    s_axi_rdata[7:0] <= tx_packet_total_q[7:0];
                `TEPI_IDX_PKT_B1:
                    s_axi_rdata[7:0] <= tx_packet_total_q[15:8];
                `TEPI_IDX_PKT_B2:
                    s_axi_rdata[7:0] <= tx_packet_total_q[23:16];
                `TEPI_IDX_BYTE_B0:
                    s_axi_rdata[7:0] <= tx_byte_total_q[7:0];
                `TEPI_IDX_BYTE_B1:
                    s_axi_rdata[7:0] <= tx_byte_total_q[15:8];
                `TEPI_IDX_BYTE_B2:
                    s_axi_rdata[7:0] <= tx_byte_total_q[23:16];
                `TEPI_IDX_BYTE_B3:
                    s_axi_rdata[7:0] <= tx_byte_total_q[31:24];
                `TEPI_IDX_PERF_UPDATE:
                    s_axi_rdata[0] <= update_q;
                default:
                    s_axi_rresp <= `TEPI_RESP_SLVERR;
            endcase
        end
    end

endmodule // tepi_top

// ===== verification/tepi_top_sva.sv
// Checker for the register bus and insertion outputs of tepi_top
module tepi_top_sva
(
    input wire clk,
    input wire rst,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire tx_pkt_done,
    input wire tx_pkt_error,
    input wire irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ****************************************
    // Bus handshakes
    // ****************************************
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_b_late;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    property p_wr_answer;
        s_wr_taken |=> s_b_late;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
    property p_rd_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    property p_b_once;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready
            && s_axi_wready;
    endproperty
    a_b_once: assert property (p_b_once) else $error("write response stuck");
    property p_r_once;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
    endproperty
    a_r_once: assert property (p_r_once) else $error("read response stuck");
    property p_refuse;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_refuse: assert property (p_refuse) else $error("write taken too early");
    // ****************************************
    // Insertion outputs
    // ****************************************
    property p_err_cause;
        tx_pkt_error |-> $past(tx_pkt_done, 2);
    endproperty
    a_err_cause: assert property (p_err_cause)
        else $error("errored pulse without packet");
    property p_irq_rise;
        $rose(irq) |-> $past(tx_pkt_error, 2) || $past(s_axi_bvalid);
    endproperty
    a_irq_rise: assert property (p_irq_rise)
        else $error("interrupt rose without cause");
    property p_irq_fall;
        $fell(irq) |-> $past(s_axi_bvalid);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt fell without a write");
endmodule // tepi_top_sva

bind tepi_top tepi_top_sva u_sva
(
    .clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .tx_pkt_done,
    .tx_pkt_error, .irq
);

// ===== verification/tepi_top_bench.sv
// Self-checking bench for the errored-packet insertion block
`include "tepi_consts.vh"

module tepi_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LIMIT = 20000;
    localparam logic [1:0] OKAY = `TEPI_RESP_OKAY;
    logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, tx_pkt_done;
    logic tx_byte_valid, tx_pkt_error, irq;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int n_mismatch = 0, compares = 0, cycles = 0, p;
    logic [7:0] rate_tab [4] = '{8'h01, 8'h0F, 8'h11, 8'h12};
    logic [7:0] zero_tab [6] = '{8'hC4, 8'hC6, 8'hC7, 8'hC8, 8'hCA, 8'hD6};

    tepi_top u_dut
    (
        .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .tx_pkt_done, .tx_byte_valid,
        .tx_pkt_error, .irq
    );

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            n_mismatch++;
            results();
        end
    end

    // ****************************************
    // Access and compare tasks
    // ****************************************
    task automatic chk_word(input string name, input logic [31:0] exp,
        input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_bit(input string name, input logic exp,
        input logic got);
        chk_word(name, {31'h0, exp}, {31'h0, got});
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] val,
        input logic [1:0] resp);
        s_axi_awaddr <= {2'h0, idx, 2'h0};
        s_axi_wdata <= {24'h0, val};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk_word("bresp", {30'h0, resp}, {30'h0, s_axi_bresp});
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] data,
        output logic [1:0] resp);
        s_axi_araddr <= {2'h0, idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        data = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] dv;
        logic [1:0] rv;
        rd(idx, dv, rv);
        chk_word($sformatf("reg %h", idx), {24'h0, exp}, dv);
        chk_word("rresp", 32'h0, {30'h0, rv});
    endtask

    task automatic cnt_chk(input logic [23:0] pk, input logic [31:0] by);
        for (int i = 0; i < 3; i++)
            rd_chk(8'hCC + i[7:0], pk[8*i +: 8]);
        for (int i = 0; i < 4; i++)
            rd_chk(8'hD0 + i[7:0], by[8*i +: 8]);
    endtask

    task automatic pkt(input int nb, input logic err);
        for (int i = 0; i < nb; i++)
        begin
            tx_byte_valid <= 1'b1;
            @(posedge clk);
        end
        tx_byte_valid <= 1'b0;
        tx_pkt_done <= 1'b1;
        @(posedge clk);
        tx_pkt_done <= 1'b0;
        // Errored flag is launched two edges after the packet strobe
        @(posedge clk);
        @(posedge clk);
        chk_bit("tx_pkt_error", err, tx_pkt_error);
    endtask

    function automatic int period(input logic [7:0] code);
        int n;
        n = code[3:0];
        repeat ((code[6:4] > 6) ? 6 : code[6:4]) n = n * 10;
        return n;
    endfunction

    task automatic run(input logic [7:0] cnt, input logic [7:0] rate);
        wr(8'hC6, cnt, OKAY);
        wr(8'hC7, rate, OKAY);
        wr(8'hC4, 8'h01, OKAY);
    endtask

    task automatic cleanup();
        wr(8'hC6, 8'h00, OKAY);
        wr(8'hC7, 8'h00, OKAY);
        wr(8'hC4, 8'h00, OKAY);
    endtask

    task automatic results();
        $display("Compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial
    begin
        rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
        {s_axi_rready, tx_pkt_done, tx_byte_valid} = 3'h0;
        s_axi_awaddr = 12'h000;
        s_axi_araddr = 12'h000;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        cnt_chk(24'h0, 32'h0);
        foreach (zero_tab[i])
            rd_chk(zero_tab[i], 8'h00);
        wr(8'hCB, 8'h5A, `TEPI_RESP_SLVERR);
        rd(8'hCB, d, r);
        chk_word("unmapped rdata", 32'h0, d);
        chk_word("unmapped rresp", 32'h2, {30'h0, r});
        wr(8'hC4, 8'h3F, OKAY);
        rd_chk(8'hC4, 8'h3E);
        wr(8'hC4, 8'h00, OKAY);
        repeat (3) pkt(100, 1'b0);
        cnt_chk(24'h0, 32'h0);
        wr(8'hD6, 8'h01, OKAY);
        cnt_chk(24'h3, 32'h12C);
        wr(8'hD6, 8'h00, OKAY);
        pkt(4, 1'b0);
        wr(8'hD6, 8'h01, OKAY);
        cnt_chk(24'h1, 32'h4);
        foreach (rate_tab[i])
        begin
            p = period(rate_tab[i]);
            run(8'h01, rate_tab[i]);
            for (int k = 1; k <= p + 2; k++)
                pkt(0, k == p);
            rd_chk(8'hC8, 8'h01);
            rd_chk(8'hC9, 8'h01);
            chk_bit("irq masked", 1'b0, irq);
            wr(8'hC9, 8'h01, OKAY);
            rd_chk(8'hC9, 8'h00);
            cleanup();
            rd_chk(8'hC8, 8'h00);
        end
        wr(8'hCA, 8'h01, OKAY);
        rd_chk(8'hCA, 8'h01);
        run(8'h02, 8'h02);
        for (int k = 1; k <= 6; k++)
            pkt(0, k == 2 || k == 4);
        rd_chk(8'hC8, 8'h01);
        chk_bit("irq", 1'b1, irq);
        wr(8'hC9, 8'h01, OKAY);
        chk_bit("irq cleared", 1'b0, irq);
        wr(8'hC4, 8'h01, OKAY);
        rd_chk(8'hC8, 8'h00);
        cleanup();
        run(8'hFF, 8'h01);
        repeat (5) pkt(0, 1'b1);
        rd_chk(8'hC8, 8'h00);
        cleanup();
        run(8'h01, 8'h10);
        repeat (3) pkt(0, 1'b0);
        rd_chk(8'hC8, 8'h00);
        cleanup();
        results();
    end
endmodule // tepi_top_bench
